// ---- hdl/sbf_device.sv ----
// Notes on behaviour
// - Fault recorded after four qualified dominant releases
// - Bit 6 half termination, bit 2 open
// - Bits 5,4,3 for line shorts
// - Bits 1,0 ground/battery; bit 7 zero
// - Frames are 16, 24 or 32 clocks
// - Burst bytes go to incremented addresses
// - Global status byte always shifted first
// - Sample on rising, change on falling
// - Output driven only while selected
// - Global fault bit shown at select
// - Select held low for whole frame
// - Write needs at least 16 clocks
// - Three-byte write is 32 clocks
// - Writes commit only at select release
// - 31 clocks commits two bytes only
// - Bad clock count sets protocol error
// - Select bit is global bit 7
// - Reads return bytes from successive addresses
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module sbf_device (
  input wire logic pclk,
  input wire logic presetn,
  sbf_if.device link,
  input wire logic [sbf_pkg::FAULT_N-1:0] fault_detect,
  input wire logic bus_dominant,
  output logic [7:0] fault_flags,
  output logic protocol_error,
  output logic global_fault
);
  // ***********************************
  // Input synchronisers
  // ***********************************
  logic cs_s, sclk_s, sdi_s, dom_s;
  logic [sbf_pkg::FAULT_N-1:0] fd_s;

  sbf_sync #(.W(sbf_pkg::FAULT_N + 4),
             .INIT({1'b1, {(sbf_pkg::FAULT_N + 3){1'b0}}})) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({link.chip_select_low, link.sclk, link.serial_in,
               bus_dominant, fault_detect}),
    .sync_out({cs_s, sclk_s, sdi_s, dom_s, fd_s})
  );

  // ***********************************
  // Fault qualification
  // ***********************************
  logic dom_prev_q, dom_prev_d;
  logic [6:0] dom_cnt_q, dom_cnt_d;
  logic qual_edge;
  logic [sbf_pkg::FAULT_N-1:0] fault_set;

  always_comb begin
    dom_prev_d = dom_s;
    dom_cnt_d = dom_cnt_q;
    if (!dom_s) begin
      dom_cnt_d = '0;
    end else if (dom_cnt_q != sbf_pkg::DOM_MIN_CYC) begin
      dom_cnt_d = dom_cnt_q + 7'h01;
    end
  end

  // A release counts only after a dominant bit of the minimum length
  assign qual_edge = dom_prev_q & ~dom_s &
                     (dom_cnt_q == sbf_pkg::DOM_MIN_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dom_prev_q <= 1'b0;
      dom_cnt_q <= '0;
    end else begin
      dom_prev_q <= dom_prev_d;
      dom_cnt_q <= dom_cnt_d;
    end
  end

  // Each flag has its own persistence count; a gap in the fault restarts it
  for (genvar i = 0; i < sbf_pkg::FAULT_N; i++) begin : g_flt
    logic [2:0] pc_q, pc_d;
    always_comb begin
      pc_d = pc_q;
      if (!fd_s[i]) begin
        pc_d = '0;
      end else if (qual_edge && pc_q != sbf_pkg::FAULT_PERSIST) begin
        pc_d = pc_q + 3'h1;
      end
    end
    assign fault_set[i] = fd_s[i] & qual_edge &
                          (pc_q == sbf_pkg::FAULT_PERSIST - 3'h1);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pc_q <= '0;
      end else begin
        pc_q <= pc_d;
      end
    end
  end

  // ***********************************
  // Serial engine and registers
  // ***********************************
  logic cs_p_q, cs_p_d, sclk_p_q, sclk_p_d;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] rx_q, rx_d, tx_q, tx_d;
  logic [6:0] addr_q, addr_d;
  logic wr_q, wr_d, sdo_q, sdo_d, oe_q, oe_d;
  logic [7:0] wbuf_q [3];
  logic [7:0] wbuf_d [3];
  logic [1:0] wcnt_q, wcnt_d;
  logic [sbf_pkg::FAULT_N-1:0] flags_q, flags_d, flags_clr;
  logic [7:0] scratch_q, scratch_d;
  logic perr_q, perr_d, perr_set, perr_clr, gflt_q, gflt_d;
  logic [7:0] status;
  logic [7:0] rd_byte;
  logic [1:0] ridx;
  logic [6:0] waddr;

  assign cs_fall = cs_p_q & ~cs_s;
  assign cs_rise = ~cs_p_q & cs_s;
  assign sclk_rise = ~sclk_p_q & sclk_s;
  assign sclk_fall = sclk_p_q & ~sclk_s;

  always_comb begin
    status = '0;
    status[sbf_pkg::GLB_FAULT_BIT] = gflt_q;
    status[sbf_pkg::GLB_BUS_BIT] = |flags_q;
    status[sbf_pkg::GLB_PERR_BIT] = perr_q;
  end

  assign ridx = 2'(cnt_q[4:3] - 2'h1);

  // Kept as a process so a flag change re-evaluates the byte at once
  always_comb begin
    rd_byte = '0;
    if (!wr_q && cnt_q <= sbf_pkg::LEN_2) begin
      case (7'(addr_q + 7'(ridx)))
        sbf_pkg::ADDR_GLOBAL: rd_byte = status;
        sbf_pkg::ADDR_FLAGS: rd_byte = {1'b0, flags_q};
        sbf_pkg::ADDR_SCRATCH: rd_byte = scratch_q;
        default: rd_byte = '0;
      endcase
    end
  end

  always_comb begin
    cs_p_d = cs_s;
    sclk_p_d = sclk_s;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    addr_d = addr_q;
    wr_d = wr_q;
    sdo_d = sdo_q;
    oe_d = ~cs_s;
    wbuf_d = wbuf_q;
    wcnt_d = wcnt_q;
    perr_set = 1'b0;
    if (cs_fall) begin
      cnt_d = '0;
      wcnt_d = '0;
      tx_d = status;
      sdo_d = status[sbf_pkg::GLB_FAULT_BIT];
    end else if (!cs_s) begin
      if (sclk_rise) begin
        rx_d = {rx_q[6:0], sdi_s};
        if (cnt_q != sbf_pkg::CNT_MAX) begin
          cnt_d = cnt_q + 6'h01;
        end
        if (cnt_q == sbf_pkg::HDR_BITS - 6'h01) begin
          addr_d = rx_q[6:0];
          wr_d = (sdi_s == sbf_pkg::RW_WRITE);
        end else if (cnt_q[2:0] == 3'h7 && !cnt_q[5] && wr_q) begin
          wbuf_d[ridx] = {rx_q[6:0], sdi_s};
          wcnt_d = 2'(ridx + 2'h1);
        end
      end
      if (sclk_fall && cnt_q != '0) begin
        if (cnt_q[2:0] == 3'h0) begin
          tx_d = rd_byte;
          sdo_d = rd_byte[7];
        end else begin
          tx_d = {tx_q[6:0], 1'b0};
          sdo_d = tx_q[6];
        end
      end
    end
    if (cs_rise && cnt_q != sbf_pkg::LEN_1 && cnt_q != sbf_pkg::LEN_2 &&
        cnt_q != sbf_pkg::LEN_3) begin
      perr_set = 1'b1;
    end
  end

  // Commit at release; up to three bytes land in one cycle
  always_comb begin
    flags_clr = '0;
    perr_clr = 1'b0;
    scratch_d = scratch_q;
    waddr = addr_q;
    if (cs_rise) begin
      for (int k = 0; k < 3; k++) begin
        waddr = 7'(addr_q + 7'(k));
        if (k < int'(wcnt_q)) begin
          case (waddr)
            sbf_pkg::ADDR_FLAGS: flags_clr = flags_clr |
                                  wbuf_q[k][sbf_pkg::FAULT_N-1:0];
            sbf_pkg::ADDR_GLOBAL: perr_clr = perr_clr |
                                  wbuf_q[k][sbf_pkg::GLB_PERR_BIT];
            sbf_pkg::ADDR_SCRATCH: scratch_d = wbuf_q[k];
            default: ;
          endcase
        end
      end
    end
    // A new event beats a clear in the same cycle
    flags_d = (flags_q & ~flags_clr) | fault_set;
    perr_d = (perr_q & ~perr_clr) | perr_set;
    gflt_d = (|flags_d) | perr_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_p_q <= 1'b1;
      sclk_p_q <= 1'b0;
      cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      addr_q <= '0;
      wr_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      wbuf_q <= '{default: '0};
      wcnt_q <= '0;
      flags_q <= sbf_pkg::FLAGS_RESET[sbf_pkg::FAULT_N-1:0];
      scratch_q <= sbf_pkg::SCRATCH_RESET;
      perr_q <= 1'b0;
      gflt_q <= 1'b0;
    end else begin
      cs_p_q <= cs_p_d;
      sclk_p_q <= sclk_p_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      wbuf_q <= wbuf_d;
      wcnt_q <= wcnt_d;
      flags_q <= flags_d;
      scratch_q <= scratch_d;
      perr_q <= perr_d;
      gflt_q <= gflt_d;
    end
  end

  assign link.serial_out = sdo_q;
  assign link.serial_out_oe = oe_q;
  assign fault_flags = {1'b0, flags_q};
  assign protocol_error = perr_q;
  assign global_fault = gflt_q;
endmodule

// ---- hdl/sbf_host.sv ----
`timescale 1ns/1ps
module sbf_host (
  input wire logic pclk,
  input wire logic presetn,
  sbf_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);
  // ***********************************
  // Data-out synchroniser
  // ***********************************
  logic so_s;

  sbf_sync #(.W(1), .INIT(1'b0)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(link.serial_line),
    .sync_out(so_s)
  );

  // ***********************************
  // APB slave and frame engine
  // ***********************************
  sbf_pkg::sbf_hstate_e st_q, st_d;
  logic [3:0] div_q, div_d;
  logic [5:0] bits_q, bits_d, nbits_q, nbits_d;
  logic [31:0] sh_q, sh_d, rx_q, rx_d, rxdata_q, rxdata_d;
  logic [31:0] txdata_q, txdata_d, prdata_d;
  logic cs_q, cs_d, sclk_q, sclk_d, sdi_q, sdi_d;
  logic pready_d, pslverr_d, busy_d, done, start;
  logic [5:0] len;

  assign done = (div_q == sbf_pkg::SCLK_HALF - 4'h1);
  assign start = psel && penable && pready && pwrite &&
                 paddr == sbf_pkg::HREG_CMD && st_q == sbf_pkg::SBF_IDLE;
  // Frame length with the trim taken off, never below zero
  always_comb begin
    len = 6'(sbf_pkg::HDR_BITS +
             6'({pwdata[sbf_pkg::CMD_NB_LSB +: 2], 3'h0}));
    if (6'(pwdata[sbf_pkg::CMD_TRIM_LSB +: 5]) > len) begin
      len = '0;
    end else begin
      len = 6'(len - 6'(pwdata[sbf_pkg::CMD_TRIM_LSB +: 5]));
    end
  end

  always_comb begin
    pready_d = psel & penable & ~pready;
    pslverr_d = 1'b0;
    prdata_d = prdata;
    txdata_d = txdata_q;
    if (psel && penable && !pready) begin
      case (paddr)
        sbf_pkg::HREG_CMD: prdata_d = '0;
        sbf_pkg::HREG_TXDATA: prdata_d = txdata_q;
        sbf_pkg::HREG_STATUS: prdata_d = {31'h0, busy};
        sbf_pkg::HREG_RXDATA: prdata_d = rxdata_q;
        default: begin
          prdata_d = '0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    if (psel && penable && pready && pwrite &&
        paddr == sbf_pkg::HREG_TXDATA) begin
      txdata_d = pwdata;
    end
  end

  always_comb begin
    st_d = st_q;
    div_d = done ? '0 : 4'(div_q + 4'h1);
    bits_d = bits_q;
    nbits_d = nbits_q;
    sh_d = sh_q;
    rx_d = rx_q;
    rxdata_d = rxdata_q;
    cs_d = cs_q;
    sclk_d = sclk_q;
    sdi_d = sdi_q;
    busy_d = busy;
    case (st_q)
      sbf_pkg::SBF_IDLE: begin
        div_d = '0;
        if (start) begin
          // Address, R/W bit, then data, all most significant bit first
          sh_d = {pwdata[6:0], pwdata[sbf_pkg::CMD_WR_BIT],
                  txdata_q[23:0]};
          sdi_d = pwdata[6];
          bits_d = len;
          nbits_d = len;
          rx_d = '0;
          cs_d = 1'b0;
          busy_d = 1'b1;
          st_d = sbf_pkg::SBF_LEAD;
        end
      end
      sbf_pkg::SBF_LEAD, sbf_pkg::SBF_LOW: begin
        if (done) begin
          if (bits_q == '0) begin
            st_d = sbf_pkg::SBF_TRAIL;
          end else begin
            sclk_d = 1'b1;
            rx_d = {rx_q[30:0], so_s};
            st_d = sbf_pkg::SBF_HIGH;
          end
        end
      end
      sbf_pkg::SBF_HIGH: begin
        if (done) begin
          sclk_d = 1'b0;
          bits_d = 6'(bits_q - 6'h01);
          sh_d = {sh_q[30:0], 1'b0};
          sdi_d = sh_q[30];
          st_d = (bits_q == 6'h01) ? sbf_pkg::SBF_TRAIL : sbf_pkg::SBF_LOW;
        end
      end
      sbf_pkg::SBF_TRAIL: begin
        if (done) begin
          cs_d = 1'b1;
          rxdata_d = rx_q << (6'h20 - nbits_q);
          st_d = sbf_pkg::SBF_GAP;
        end
      end
      sbf_pkg::SBF_GAP: begin
        if (done) begin
          busy_d = 1'b0;
          st_d = sbf_pkg::SBF_IDLE;
        end
      end
      default: st_d = sbf_pkg::SBF_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= sbf_pkg::SBF_IDLE;
      div_q <= '0;
      bits_q <= '0;
      nbits_q <= '0;
      sh_q <= '0;
      rx_q <= '0;
      rxdata_q <= '0;
      txdata_q <= '0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      busy <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      bits_q <= bits_d;
      nbits_q <= nbits_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      rxdata_q <= rxdata_d;
      txdata_q <= txdata_d;
      cs_q <= cs_d;
      sclk_q <= sclk_d;
      sdi_q <= sdi_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      busy <= busy_d;
    end
  end

  assign link.chip_select_low = cs_q;
  assign link.sclk = sclk_q;
  assign link.serial_in = sdi_q;
endmodule

// ---- hdl/sbf_if.sv ----
`timescale 1ns/1ps
interface sbf_if;
  logic chip_select_low;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic serial_line;

  // Released data-out line rests high, as a pulled-up shared bus would
  assign serial_line = serial_out_oe ? serial_out : 1'b1;

  modport device (
    input chip_select_low,
    input sclk,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );
  modport host (
    output chip_select_low,
    output sclk,
    output serial_in,
    input serial_line
  );
endinterface

// ---- hdl/sbf_pkg.sv ----
package sbf_pkg;
  // ***********************************
  // Clock and timing
  // ***********************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int DOM_MIN_NS = 2000;
  localparam int DOM_MIN_CYC_I = (DOM_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [6:0] DOM_MIN_CYC = 7'(DOM_MIN_CYC_I);
  localparam logic [2:0] FAULT_PERSIST = 3'h4;
  // Half period of the serial clock made by the controller, in pclk cycles
  localparam logic [3:0] SCLK_HALF = 4'h8;

  // ***********************************
  // Device register map (7-bit addresses)
  // ***********************************
  localparam logic [6:0] ADDR_SCRATCH = 7'h0F;
  localparam logic [6:0] ADDR_GLOBAL = 7'h50;
  localparam logic [6:0] ADDR_FLAGS = 7'h54;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam int FAULT_N = 7;
  localparam int GLB_FAULT_BIT = 7;
  localparam int GLB_BUS_BIT = 5;
  localparam int GLB_PERR_BIT = 3;
  localparam int FLG_HALF_TERM = 6;
  localparam int FLG_SHORTED = 5;
  localparam int FLG_HI_BAT = 4;
  localparam int FLG_LO_GND = 3;
  localparam int FLG_OPEN = 2;
  localparam int FLG_GND = 1;
  localparam int FLG_BAT = 0;

  // ***********************************
  // Serial frame
  // ***********************************
  localparam logic RW_WRITE = 1'b1;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [5:0] LEN_1 = 6'h10;
  localparam logic [5:0] LEN_2 = 6'h18;
  localparam logic [5:0] LEN_3 = 6'h20;
  localparam logic [5:0] HDR_BITS = 6'h08;

  // ***********************************
  // Controller registers over APB
  // ***********************************
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_TXDATA = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam logic [7:0] HREG_RXDATA = 8'h0C;
  localparam int CMD_WR_BIT = 7;
  localparam int CMD_NB_LSB = 8;
  localparam int CMD_TRIM_LSB = 10;

  typedef enum {
    SBF_IDLE, SBF_LEAD, SBF_HIGH, SBF_LOW, SBF_TRAIL, SBF_GAP
  } sbf_hstate_e;
endpackage

// ---- hdl/sbf_sync.sv ----
`timescale 1ns/1ps
module sbf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ---- verification/sbf_checker.sv ----
`timescale 1ns/1ps
module sbf_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_select_low,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // ***********************************
  // Edge age helpers
  // ***********************************
  logic sclk_p_q, sclk_p_d, cs_p_q, cs_p_d, so_p_q, so_p_d;
  logic [3:0] age_q, age_d, low_q, low_d;

  // Saturating ages, so long idle spans never wrap into a false pass
  always_comb begin
    sclk_p_d = sclk;
    cs_p_d = chip_select_low;
    so_p_d = serial_out;
    age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
    if ((sclk_p_q && !sclk) || (cs_p_q && !chip_select_low)) begin
      age_d = 4'h0;
    end
    low_d = (low_q == 4'hF) ? low_q : low_q + 4'h1;
    if (sclk) begin
      low_d = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      so_p_q <= 1'b0;
      age_q <= 4'hF;
      low_q <= 4'h0;
    end else begin
      sclk_p_q <= sclk_p_d;
      cs_p_q <= cs_p_d;
      so_p_q <= so_p_d;
      age_q <= age_d;
      low_q <= low_d;
    end
  end

  // ***********************************
  // Assertions
  // ***********************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_oe_off_idle: assert property (chip_select_low [*5] |-> !serial_out_oe)
    else $error("data out driven while not selected");
  a_oe_on_select: assert property (!chip_select_low [*5] |-> serial_out_oe)
    else $error("data out not driven while selected");
  a_select_drive_fast: assert property ($fell(chip_select_low) |-> ##[0:4] serial_out_oe)
    else $error("data out late after select");
  a_out_after_fall: assert property ((serial_out != so_p_q) && serial_out_oe
    && !chip_select_low |-> age_q <= 4'h5)
    else $error("data out changed away from a clock fall");
  a_sin_hold_rise: assert property ($rose(sclk) |-> $stable(serial_in))
    else $error("data in changed at clock rise");
  a_sclk_idle_low: assert property (chip_select_low |-> !sclk)
    else $error("serial clock high outside frame");
  a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*6])
    else $error("serial clock high phase too short");
  a_cs_lead_time: assert property ($fell(chip_select_low) |-> !sclk [*6])
    else $error("clock too soon after select");
  a_cs_trail_time: assert property ($rose(chip_select_low) |-> low_q >= 4'h6)
    else $error("select released too soon after clock");

  c_frame: cover property ($rose(chip_select_low));
  c_clock: cover property ($rose(sclk) && !chip_select_low);
  c_drive: cover property ($rose(serial_out_oe));
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [6:0] fault_detect = 7'h00;
  logic bus_dominant = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, protocol_error, global_fault;
  logic [7:0] fault_flags;
  logic [7:0] exp_flags = 8'h00;
  logic exp_perr = 1'b0;
  logic [31:0] rx;
  logic err;
  int errors = 0;
  int checks_done = 0;

  always #12.5 pclk = ~pclk;

  sbf_if sbf_if_i ();
  sbf_device sbf_device_i (.pclk(pclk), .presetn(presetn),
    .link(sbf_if_i.device), .fault_detect(fault_detect),
    .bus_dominant(bus_dominant), .fault_flags(fault_flags),
    .protocol_error(protocol_error), .global_fault(global_fault));
  sbf_host sbf_host_i (.pclk(pclk), .presetn(presetn),
    .link(sbf_if_i.host), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  sbf_checker sbf_checker_i (.pclk(pclk), .presetn(presetn),
    .chip_select_low(sbf_if_i.chip_select_low), .sclk(sbf_if_i.sclk),
    .serial_in(sbf_if_i.serial_in), .serial_out(sbf_if_i.serial_out),
    .serial_out_oe(sbf_if_i.serial_out_oe));

  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Global status byte as the bench expects it right now
  function automatic logic [7:0] gbyte();
    return {(|exp_flags) | exp_perr, 1'b0, |exp_flags, 1'b0, exp_perr, 3'h0};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One serial frame; the select-time bit is judged before any clock
  task automatic frame(input logic [6:0] a, input logic wr,
                       input logic [1:0] nb, input logic [4:0] trim,
                       input logic [23:0] tx);
    logic [31:0] st;
    logic e;
    apb(1'b1, sbf_pkg::HREG_TXDATA, {8'h00, tx}, st, e);
    apb(1'b1, sbf_pkg::HREG_CMD, {17'h00000, trim, nb, wr, a}, st, e);
    while (sbf_if_i.serial_out_oe !== 1'b1) begin
      @(posedge pclk);
    end
    @(posedge pclk);
    check("select_bit", {31'h0, gbyte()}>>7, {31'h0, sbf_if_i.serial_line});
    check("busy", 32'h1, {31'h0, busy});
    st = 32'h00000001;
    // A long frame outlasts many polls; the watchdog bounds this wait
    while (st[0] !== 1'b0) begin
      apb(1'b0, sbf_pkg::HREG_STATUS, 32'h0, st, e);
    end
    apb(1'b0, sbf_pkg::HREG_RXDATA, 32'h0, rx, e);
    repeat (8) @(posedge pclk);
  endtask

  task automatic releases(input int n, input int dom);
    repeat (n) begin
      bus_dominant <= 1'b1;
      repeat (dom) @(posedge pclk);
      bus_dominant <= 1'b0;
      repeat (20) @(posedge pclk);
    end
  endtask

  // ***********************************
  // Scenarios
  // ***********************************
  task automatic t_reset;
    check("flags_port", 32'h0, {24'h0, fault_flags});
    check("global_fault", 32'h0, {31'h0, global_fault});
    frame(sbf_pkg::ADDR_FLAGS, 1'b0, 2'h1, 5'h00, 24'h0);
    check("flags_read", {gbyte(), 8'h00}, rx[31:16]);
    apb(1'b0, 8'h10, 32'h0, rx, err);
    check("unmapped", 32'h1, {rx[30:0], err});
  endtask

  task automatic t_faults;
    fault_detect <= 7'h40;
    releases(4, 60);
    check("short_dominant", 32'h0, {24'h0, fault_flags});
    for (int i = 0; i < 7; i++) begin
      fault_detect <= 7'(1 << i);
      releases(3, 90);
      check("three_releases", {24'h0, exp_flags}, {24'h0, fault_flags});
      releases(1, 90);
      exp_flags[i] = 1'b1;
      check("fault_bit", {24'h0, exp_flags}, {24'h0, fault_flags});
    end
    fault_detect <= 7'h00;
    check("all_flags", 32'h7F, {24'h0, fault_flags});
  endtask

  task automatic t_read_burst;
    frame(sbf_pkg::ADDR_FLAGS, 1'b0, 2'h3, 5'h00, 24'h0);
    check("status_first", {24'h0, gbyte()}, {24'h0, rx[31:24]});
    check("burst_read", {8'h7F, 16'h0}, {8'h0, rx[23:0]});
  endtask

  task automatic t_clear;
    logic [7:0] g;
    g = gbyte();
    frame(sbf_pkg::ADDR_FLAGS, 1'b1, 2'h1, 5'h00, 24'h0A0000);
    check("write_status", {g, 24'h0}, rx);
    exp_flags = 8'h75;
    check("w1c", {24'h0, exp_flags}, {24'h0, fault_flags});
    frame(sbf_pkg::ADDR_FLAGS, 1'b1, 2'h1, 5'h00, 24'h0);
    check("w0_keeps", {24'h0, exp_flags}, {24'h0, fault_flags});
  endtask

  // Burst lands on 0x0E..0x10; only the scratch byte is observable
  task automatic t_burst_write;
    frame(7'h0E, 1'b1, 2'h3, 5'h00, 24'hA55AC3);
    check("no_error", 32'h0, {31'h0, protocol_error});
    frame(7'h0E, 1'b0, 2'h2, 5'h00, 24'h0);
    check("burst_incr", 32'h005A, {16'h0, rx[23:8]});
  endtask

  task automatic t_short_frames;
    frame(7'h0E, 1'b1, 2'h3, 5'h01, 24'h112233);
    exp_perr = 1'b1;
    check("err_31", 32'h1, {31'h0, protocol_error});
    frame(7'h0D, 1'b1, 2'h3, 5'h01, 24'h445566);
    frame(sbf_pkg::ADDR_GLOBAL, 1'b1, 2'h1, 5'h00, 24'h080000);
    exp_perr = 1'b0;
    check("err_clear", 32'h0, {31'h0, protocol_error});
    frame(sbf_pkg::ADDR_SCRATCH, 1'b1, 2'h0, 5'h00, 24'h0);
    exp_perr = 1'b1;
    check("err_8", 32'h1, {31'h0, protocol_error});
    check("global_fault", 32'h1, {31'h0, global_fault});
    frame(sbf_pkg::ADDR_SCRATCH, 1'b0, 2'h1, 5'h00, 24'h0);
    check("partial_commit", {gbyte(), 8'h22}, rx[31:16]);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_faults();
    t_read_burst();
    t_clear();
    t_burst_write();
    t_short_frames();
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    stop_test();
  end
endmodule
